// ---- design/pack_shutdown_safety_ctrl.v ----
// Pack shutdown sequencer, keep-alive control and temperature safety signal
// What this block does
// - Shutdown sense low stops activity and zeroes regulator output.
// - Sense rising high triggers power-on reset then closes charge and discharge switches.
// - Every cell voltage is compared against a programmable minimum threshold.
// - Cell low for programmed cycles: open discharge switch, then float keep-alive.
// - After collapse, stay off until sense input rises again.
// - After reset, measure all cells; drive keep-alive high only if all healthy.
// - While cells healthy, keep-alive stays driven and both switches stay closed.
// - Temperature compared with cold and hot thresholds gives hot, normal or cold.
// - Hot gives A0 B1, normal A1 B0, cold A0 B0.
// - Eight high-voltage outputs follow an output register; 0-5 pull low, 6-7 up.
// - Keep-alive high holds the sense input above the shutdown level.
`timescale 1ns/1ps
`include "pack_shutdown_safety_defs.vh"
module pack_shutdown_safety_ctrl #(
  parameter NCELL = 4
) (
  input  wire                       i_ref_clk,
  input  wire                       i_resetn,
  input  wire                       i_shutdown_sense,
  input  wire                       i_meas_valid,
  input  wire [1:0]                 i_meas_idx,
  input  wire [`CELL_W-1:0]         i_cell_mv,
  input  wire [`CELL_W-1:0]         i_cell_min_mv,
  input  wire [`CNT_W-1:0]          i_low_cycles,
  input  wire                       i_temp_valid,
  input  wire [`TEMP_W-1:0]         i_temp,
  input  wire [`TEMP_W-1:0]         i_temp_cold,
  input  wire [`TEMP_W-1:0]         i_temp_hot,
  input  wire                       i_hv_we,
  input  wire [`HV_W-1:0]           i_hv_wdata,
  output reg                        o_active,
  output reg                        o_regulator_output,
  output reg                        o_charge_switch_drive,
  output reg                        o_discharge_switch_drive,
  output reg                        o_keep_alive_pin,
  output reg                        o_keep_alive_pin_oen,
  output reg                        o_safety_out_a,
  output reg                        o_safety_out_b,
  output reg  [`HV_W-1:0]           o_high_voltage_outputs,
  output reg  [`HV_W-1:0]           o_high_voltage_outputs_oen
);
  // =============================================================
  // Sense input synchroniser: three stages, change counts when 2 and 3 agree
  // Reset low, so the block wakes in its off state until the sense input rises
  reg                 sense_s1_ff;
  reg                 sense_s2_ff;
  reg                 sense_s3_ff;
  reg                 sense_ff;
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sense_s1_ff <= 1'b0;
      sense_s2_ff <= 1'b0;
      sense_s3_ff <= 1'b0;
      sense_ff    <= 1'b0;
    end else begin
      sense_s1_ff <= i_shutdown_sense;
      sense_s2_ff <= sense_s1_ff;
      sense_s3_ff <= sense_s2_ff;
      if (sense_s2_ff == sense_s3_ff) begin
        sense_ff <= sense_s3_ff;
      end
    end
  end

  // =============================================================
  // Cell comparison and per-cell flags
  wire                cell_low;
  wire [NCELL-1:0]    low_flags;
  wire                last_cell;
  assign cell_low  = (i_cell_mv < i_cell_min_mv);
  assign last_cell = (i_meas_idx == NCELL - 1);

  cell_min_store #(
    .N (NCELL)
  ) u_store (
    .i_ref_clk   (i_ref_clk),
    .i_resetn    (i_resetn),
    .i_we        (i_meas_valid),
    .i_idx       (i_meas_idx),
    .i_low       (cell_low),
    .o_low_flags (low_flags)
  );

  // Cycle end flag: set on the same edge that stores the last cell's flag
  // Stale flags still count when a cell is skipped within a cycle
  reg                 cycle_done_ff;
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cycle_done_ff <= 1'b0;
    end else begin
      cycle_done_ff <= i_meas_valid & last_cell;
    end
  end
  wire                any_low;
  wire                cycle_good;
  assign any_low    = |low_flags;
  assign cycle_good = cycle_done_ff & ~any_low;

  // =============================================================
  // Sequencer
  localparam [5:0] ST_OFF      = `ST_OFF;
  localparam [5:0] ST_POR      = `ST_POR;
  localparam [5:0] ST_CHECK    = `ST_CHECK;
  localparam [5:0] ST_RUN      = `ST_RUN;
  localparam [5:0] ST_OPEN_DIS = `ST_OPEN_DIS;
  localparam [5:0] ST_RELEASE  = `ST_RELEASE;

  reg  [5:0]          state_ff;
  reg  [5:0]          nxt_state;
  reg  [`CNT_W-1:0]   low_cnt_ff;
  reg  [`CNT_W-1:0]   nxt_low_cnt;
  reg                 chg_ff;
  reg                 dis_ff;
  reg                 nxt_chg;
  reg                 nxt_dis;

  always @* begin
    nxt_state   = state_ff;
    nxt_low_cnt = low_cnt_ff;
    nxt_chg     = chg_ff;
    nxt_dis     = dis_ff;
    case (state_ff)
      ST_OFF: begin
        nxt_chg = 1'b0;
        nxt_dis = 1'b0;
        nxt_low_cnt = {`CNT_W{1'b0}};
        if (sense_ff) begin
          nxt_state = ST_POR;
        end
      end
      ST_POR: begin
        nxt_chg   = 1'b1;
        nxt_dis   = 1'b1;
        nxt_state = ST_CHECK;
      end
      ST_CHECK: begin
        // Waits for a full measurement cycle with no low cell; keep-alive stays floating until then
        nxt_low_cnt = {`CNT_W{1'b0}};
        if (cycle_good) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (cycle_done_ff) begin
          if (any_low) begin
            // A limit of 0 or 1 both trip on the first low cycle
            if (low_cnt_ff + 8'h01 >= i_low_cycles) begin
              nxt_state = ST_OPEN_DIS;
            end
            nxt_low_cnt = low_cnt_ff + 8'h01;
          end else begin
            nxt_low_cnt = {`CNT_W{1'b0}};
          end
        end
      end
      ST_OPEN_DIS: begin
        nxt_dis   = 1'b0;
        nxt_state = ST_RELEASE;
      end
      ST_RELEASE: begin
        // Waits here for the sense collapse; a charger can keep it high
        nxt_dis   = 1'b0;
        nxt_state = ST_RELEASE;
      end
      default: begin
        nxt_state = ST_OFF;
      end
    endcase
    // Switches open together with the halt, so nothing stays closed while off
    if (!sense_ff) begin
      nxt_state   = ST_OFF;
      nxt_chg     = 1'b0;
      nxt_dis     = 1'b0;
      nxt_low_cnt = {`CNT_W{1'b0}};
    end
  end

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff   <= ST_OFF;
      low_cnt_ff <= {`CNT_W{1'b0}};
      chg_ff     <= 1'b0;
      dis_ff     <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      low_cnt_ff <= nxt_low_cnt;
      chg_ff     <= nxt_chg;
      dis_ff     <= nxt_dis;
    end
  end

  // =============================================================
  // Pin outputs
  wire                run_like;
  wire                powered;
  assign run_like = (state_ff == ST_RUN) | (state_ff == ST_OPEN_DIS);
  assign powered  = (nxt_state != ST_OFF);
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_active                 <= 1'b0;
      o_regulator_output       <= 1'b0;
      o_charge_switch_drive    <= 1'b0;
      o_discharge_switch_drive <= 1'b0;
      o_keep_alive_pin         <= 1'b0;
      o_keep_alive_pin_oen     <= 1'b1;
    end else begin
      o_active                 <= powered;
      o_regulator_output       <= powered;
      o_charge_switch_drive    <= nxt_chg;
      o_discharge_switch_drive <= nxt_dis;
      // Drive high props up the sense input through the diode
      o_keep_alive_pin         <= run_like & powered;
      o_keep_alive_pin_oen     <= ~(run_like & powered);
    end
  end

  // =============================================================
  // Temperature classification, one-hot pack state
  localparam [2:0] PK_COLD   = 3'b001;
  localparam [2:0] PK_NORMAL = 3'b010;
  localparam [2:0] PK_HOT    = 3'b100;

  reg  [2:0]          pack_state;
  // Hot is tested first, so crossed thresholds read as hot
  always @* begin
    if (i_temp >= i_temp_hot) begin
      pack_state = PK_HOT;
    end else if (i_temp <= i_temp_cold) begin
      pack_state = PK_COLD;
    end else begin
      pack_state = PK_NORMAL;
    end
  end

  // =============================================================
  // Safety signal pins; quiet while the sense input is low
  reg                 nxt_safe_a;
  reg                 nxt_safe_b;
  always @* begin
    nxt_safe_a = o_safety_out_a;
    nxt_safe_b = o_safety_out_b;
    if (!sense_ff) begin
      nxt_safe_a = 1'b0;
      nxt_safe_b = 1'b0;
    end else if (i_temp_valid) begin
      case (pack_state)
        PK_HOT: begin
          nxt_safe_a = 1'b0;
          nxt_safe_b = 1'b1;
        end
        PK_NORMAL: begin
          nxt_safe_a = 1'b1;
          nxt_safe_b = 1'b0;
        end
        default: begin
          nxt_safe_a = 1'b0;
          nxt_safe_b = 1'b0;
        end
      endcase
    end
  end

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_safety_out_a <= 1'b0;
      o_safety_out_b <= 1'b0;
    end else begin
      o_safety_out_a <= nxt_safe_a;
      o_safety_out_b <= nxt_safe_b;
    end
  end

  // =============================================================
  // High-voltage output register; a 1 turns the driver on
  // Kept through shutdown; only reset clears it
  reg  [`HV_W-1:0]    hv_reg_ff;
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hv_reg_ff <= {`HV_W{1'b0}};
    end else if (i_hv_we) begin
      hv_reg_ff <= i_hv_wdata;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `HV_W; g = g + 1) begin : g_hv
      always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          o_high_voltage_outputs[g]     <= 1'b0;
          o_high_voltage_outputs_oen[g] <= 1'b1;
        end else begin
          // Low-side for 0-5, high-side for 6-7; off means floating
          o_high_voltage_outputs[g]     <= (g >= `HV_PULL_LOW_W);
          o_high_voltage_outputs_oen[g] <= ~hv_reg_ff[g];
        end
      end
    end
  endgenerate
endmodule // pack_shutdown_safety_ctrl

// ---- design/pack_shutdown_safety_defs.vh ----
// Constants for the pack shutdown and safety controller
`ifndef PACK_SHUTDOWN_SAFETY_DEFS_VH
`define PACK_SHUTDOWN_SAFETY_DEFS_VH
// =============================================================
// Widths and defaults
`define CELL_W          12
`define TEMP_W          12
`define CELL_MIN_DEF    12'h9C4
`define LOW_CYC_DEF     8'h04
`define CNT_W           8
`define HV_W            8
`define HV_PULL_LOW_W   6
// =============================================================
// Sequencer states, one-hot
`define ST_OFF          6'h01
`define ST_POR          6'h02
`define ST_CHECK        6'h04
`define ST_RUN          6'h08
`define ST_OPEN_DIS     6'h10
`define ST_RELEASE      6'h20
`endif

// ---- design/cell_min_store.v ----
// Small register store holding the per-cell latest low flags
`timescale 1ns/1ps
module cell_min_store #(
  parameter N = 4
) (
  input  wire         i_ref_clk,
  input  wire         i_resetn,
  input  wire         i_we,
  input  wire [1:0]   i_idx,
  input  wire         i_low,
  output reg  [N-1:0] o_low_flags
);
  // =============================================================
  // Storage, read data straight from a register
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_low_flags <= {N{1'b0}};
    end else if (i_we) begin
      o_low_flags[i_idx] <= i_low;
    end
  end
endmodule // cell_min_store

// ---- tb/pack_charger_model.sv ----
// Far-side model: charger source and keep-alive diode onto the sense input
`timescale 1ns/1ps
module pack_charger_model (
  input  wire i_charger_on,
  input  wire i_keep_alive_pin,
  input  wire i_keep_alive_pin_oen,
  output wire o_shutdown_sense
);
  // =============================================================
  // Sense node
  // Diode conducts only while the pin is driven high; a floating pin adds nothing
  assign o_shutdown_sense = i_charger_on | (~i_keep_alive_pin_oen & i_keep_alive_pin);
endmodule // pack_charger_model

// ---- tb/pack_safety_properties.sv ----
// Port assertions for the pack shutdown and safety controller
`timescale 1ns/1ps
module pack_safety_properties (
  input wire        i_ref_clk,
  input wire        i_resetn,
  input wire        i_shutdown_sense,
  input wire        i_temp_valid,
  input wire [11:0] i_temp,
  input wire [11:0] i_temp_cold,
  input wire [11:0] i_temp_hot,
  input wire        i_hv_we,
  input wire [7:0]  i_hv_wdata,
  input wire        o_active,
  input wire        o_regulator_output,
  input wire        o_charge_switch_drive,
  input wire        o_discharge_switch_drive,
  input wire        o_keep_alive_pin,
  input wire        o_keep_alive_pin_oen,
  input wire        o_safety_out_a,
  input wire        o_safety_out_b,
  input wire [7:0]  o_high_voltage_outputs,
  input wire [7:0]  o_high_voltage_outputs_oen
);
  // =============================================================
  // Assertions
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // Six low samples cover the sense filter latency with margin
  off_when_low_a: assert property (!i_shutdown_sense [*6] |=> !o_active && !o_regulator_output
    && !o_charge_switch_drive && !o_discharge_switch_drive) else $error("not off");
  start_on_a: assert property (i_shutdown_sense [*6] |=> o_active) else $error("no start");
  start_sw_a: assert property ($rose(o_active) |-> ##[0:3]
    (o_charge_switch_drive && o_discharge_switch_drive)) else $error("switches open");
  alive_valid_a: assert property (!o_keep_alive_pin_oen |-> o_keep_alive_pin && o_active)
    else $error("bad keep alive");
  open_order_a: assert property ($rose(o_keep_alive_pin_oen) && o_active
    |-> !o_discharge_switch_drive) else $error("release before open");
  temp_hot_a: assert property (i_temp_valid && o_active && i_temp >= i_temp_hot
    |=> !o_safety_out_a && o_safety_out_b) else $error("hot code");
  temp_norm_a: assert property (i_temp_valid && o_active && i_temp > i_temp_cold
    && i_temp < i_temp_hot |=> o_safety_out_a && !o_safety_out_b) else $error("normal code");
  temp_cold_a: assert property (i_temp_valid && o_active && i_temp <= i_temp_cold
    |=> !o_safety_out_a && !o_safety_out_b) else $error("cold code");
  hv_write_a: assert property (i_hv_we |-> ##[1:3] (o_high_voltage_outputs_oen == ~i_hv_wdata
    && o_high_voltage_outputs == 8'hC0)) else $error("hv output");
  cover property ($fell(o_keep_alive_pin_oen));
  cover property ($rose(o_keep_alive_pin_oen) && o_active);
  cover property (i_temp_valid && i_temp >= i_temp_hot);
endmodule // pack_safety_properties
bind pack_shutdown_safety_ctrl pack_safety_properties u_props (.*);

// ---- tb/tb.sv ----
// Self-checking bench for the pack shutdown and safety controller
`timescale 1ns/1ps
module tb;
  reg         clk, rstn, chg_src, mv_v, t_v, hv_we;
  reg  [1:0]  idx;
  reg  [11:0] mv, cmin, tmp, tc, th;
  reg  [7:0]  lowc, hvd;
  wire        sense, act, rego, charge_switch_drive, dis, ka, ka_oen, sa, sb;
  wire [7:0]  hv, hv_oen;
  integer     error_cnt, checks, i, k;
  pack_charger_model u_pack (.i_charger_on(chg_src), .i_keep_alive_pin(ka),
    .i_keep_alive_pin_oen(ka_oen), .o_shutdown_sense(sense));
  pack_shutdown_safety_ctrl dut_u (.i_ref_clk(clk), .i_resetn(rstn), .i_shutdown_sense(sense),
    .i_meas_valid(mv_v), .i_meas_idx(idx), .i_cell_mv(mv), .i_cell_min_mv(cmin),
    .i_low_cycles(lowc), .i_temp_valid(t_v), .i_temp(tmp), .i_temp_cold(tc), .i_temp_hot(th),
    .i_hv_we(hv_we), .i_hv_wdata(hvd), .o_active(act), .o_regulator_output(rego),
    .o_charge_switch_drive(charge_switch_drive), .o_discharge_switch_drive(dis), .o_keep_alive_pin(ka),
    .o_keep_alive_pin_oen(ka_oen), .o_safety_out_a(sa), .o_safety_out_b(sb),
    .o_high_voltage_outputs(hv), .o_high_voltage_outputs_oen(hv_oen));
  // =============================================================
  // Shared tasks
  task chk(input [11:0] got, input [11:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t got %0h exp %0h", $time, got, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("counts: %0d checks, %0d errors", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // A used-up wait bound is a failure and ends the run
  task tmo(input integer n);
    begin
      if (n >= 60) begin
        error_cnt = error_cnt + 1;
        end_of_test;
      end
    end
  endtask
  // One full measurement cycle, cell 2 at v and the rest exactly at threshold
  task cell_cycle(input [11:0] v);
    begin
      for (k = 0; k < 4; k = k + 1) begin
        @(posedge clk);
        mv_v <= 1'b1;
        idx <= k[1:0];
        mv <= (k == 2) ? v : cmin;
      end
      @(posedge clk);
      mv_v <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
    end
  endtask
  // =============================================================
  // Scenario tasks
  // Charger raises the sense input; switches close, keep-alive still floats
  task start_up;
    begin
      @(posedge clk);
      chg_src <= 1'b1;
      for (i = 0; i < 60 && !(charge_switch_drive && dis); i = i + 1) @(negedge clk);
      tmo(i);
      chk(act, 1'b1);
      chk(rego, 1'b1);
      chk(ka_oen, 1'b1);
      $display("start done");
    end
  endtask
  // A low cell holds the check state; a healthy cycle starts the run
  task healthy_run;
    begin
      cell_cycle(cmin - 12'h001);
      chk(ka_oen, 1'b1);
      cell_cycle(cmin);
      for (i = 0; i < 60 && ka_oen !== 1'b0; i = i + 1) @(negedge clk);
      tmo(i);
      chk(ka, 1'b1);
      @(posedge clk);
      chg_src <= 1'b0;
      repeat (12) @(negedge clk);
      chk({act, sense, ka}, 12'h007);
      $display("run done");
    end
  endtask
  // Temperature below cold, on both thresholds and between them
  task temp_codes;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        @(posedge clk);
        t_v <= 1'b1;
        tmp <= {k[3:0], 8'h00};
        @(posedge clk);
        t_v <= 1'b0;
        @(negedge clk);
        chk({sa, sb}, (k == 3) ? 12'h001 : (k == 2) ? 12'h002 : 12'h000);
      end
      $display("temp done");
    end
  endtask
  task hv_write;
    begin
      @(posedge clk);
      hv_we <= 1'b1;
      hvd <= 8'hA5;
      @(posedge clk);
      hv_we <= 1'b0;
      repeat (4) @(negedge clk);
      chk(hv_oen, 12'h05A);
      chk(hv, 12'h0C0);
      $display("hv done");
    end
  endtask
  // Low cycles with one healthy cycle between; the count must restart
  task undervoltage_shutdown;
    begin
      cell_cycle(12'h100);
      cell_cycle(12'h100);
      cell_cycle(cmin);
      cell_cycle(12'h100);
      cell_cycle(12'h100);
      chk({ka_oen, dis}, 12'h001);
      cell_cycle(12'h100);
      chk({act, dis, ka_oen}, 12'h005);
      for (i = 0; i < 60 && act !== 1'b0; i = i + 1) @(negedge clk);
      tmo(i);
      chk({dis, rego, charge_switch_drive, ka_oen}, 12'h001);
      repeat (40) @(negedge clk);
      chk(act, 1'b0);
      $display("shutdown done");
    end
  endtask
  // =============================================================
  // Scenarios
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rstn, chg_src, mv_v, t_v, hv_we, idx, hvd} = 0;
    mv = 12'h000;
    cmin = 12'h9C4;
    lowc = 8'h03;
    tmp = 12'h000;
    tc = 12'h100;
    th = 12'h300;
    error_cnt = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    start_up;
    healthy_run;
    temp_codes;
    hv_write;
    undervoltage_shutdown;
    start_up;
    end_of_test;
  end
endmodule // tb
